// ### include/hbrg_pkg.sv
// What this block does
// - Bus master releases bus, then grants
// - Release floats address, data, selects, strobes
// - Host request outranks every peer request
// - Grant held low until request withdrawn
// - Only bus master drives grant; others monitor
// - Grant floats one clock before going low
// - Chip select plus request pulls acknowledge low
`default_nettype none
package hbrg_pkg;
  localparam int unsigned PEER_COUNT = 6;
  localparam int unsigned FLOAT_CYCLES = 1;
  // Internal bus driver enables, one per pin group
  typedef struct packed {
    logic addr;
    logic data;
    logic sel;
    logic strobe;
  } hbrg_bus_oe_s;
  localparam hbrg_bus_oe_s BUS_OFF = 4'h0;
  localparam hbrg_bus_oe_s BUS_ON  = 4'hF;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RELEASE,
    ST_FLOAT,
    ST_GRANT,
    ST_RESUME
  } hbrg_state_e;
endpackage
`default_nettype wire

// ### src/hbrg_top.sv
`timescale 1ns/1ps
`default_nettype none
module hbrg_top #(
  parameter int unsigned PEERS = hbrg_pkg::PEER_COUNT
) (
  // Clock and reset
  input  wire logic                core_clk_in,
  input  wire logic                sys_rst_in,
  // Host pins
  input  wire logic                host_bus_request_n_in,
  input  wire logic                chip_select_n_in,
  input  wire logic                host_bus_grant_n_in,
  output logic                     host_bus_grant_n_out,
  output logic                     host_bus_grant_oe_out,
  output logic                     host_wait_ack_out,
  output logic                     host_wait_ack_oe_out,
  // Multiprocessor arbitration
  input  wire logic [PEERS-1:0]    peer_bus_requests_n_in,
  input  wire logic                own_bus_master_in,
  output logic                     own_bus_request_n_out,
  // Core side
  input  wire logic                core_bus_want_in,
  output hbrg_pkg::hbrg_bus_oe_s   bus_oe_out,
  output logic                     host_granted_out
);
  // Peer field cannot be wider than the peer count
  if (PEERS < 1 || PEERS > hbrg_pkg::PEER_COUNT) begin : g_bad_peers
    $error("PEERS out of range");
  end

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  // All pins are asynchronous; only the second stage is ever read
  logic             hbr_sync;
  logic             cs_sync;
  logic             gnt_sync;
  logic [PEERS-1:0] peer_sync;
  hbrg_sync2 #(
    .WIDTH (1)
  ) hbr_sync2_inst (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .async_in    (host_bus_request_n_in),
    .sync_out    (hbr_sync)
  );
  hbrg_sync2 #(
    .WIDTH (1)
  ) cs_sync2_inst (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .async_in    (chip_select_n_in),
    .sync_out    (cs_sync)
  );
  hbrg_sync2 #(
    .WIDTH (1)
  ) gnt_sync2_inst (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .async_in    (host_bus_grant_n_in),
    .sync_out    (gnt_sync)
  );
  hbrg_sync2 #(
    .WIDTH (PEERS)
  ) peer_sync2_inst (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .async_in    (peer_bus_requests_n_in),
    .sync_out    (peer_sync)
  );
  logic host_req;
  logic host_sel;
  logic peer_req;
  logic mon_grant;
  assign host_req  = ~hbr_sync;
  assign host_sel  = ~cs_sync;
  assign peer_req  = ~&peer_sync;
  assign mon_grant = ~gnt_sync;

  ////////////////////////////////////////////////////////////////////
  // Handover state machine
  hbrg_pkg::hbrg_state_e state_reg;
  logic [1:0]            float_cnt_reg;
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state_reg     <= hbrg_pkg::ST_IDLE;
      float_cnt_reg <= 2'h0;
    end else begin
      case (state_reg)
        hbrg_pkg::ST_IDLE: begin
          // Only the bus master answers the host
          if (host_req && own_bus_master_in) begin
            state_reg <= hbrg_pkg::ST_RELEASE;
          end
        end
        hbrg_pkg::ST_RELEASE: begin
          float_cnt_reg <= 2'h0;
          state_reg     <= hbrg_pkg::ST_FLOAT;
        end
        hbrg_pkg::ST_FLOAT: begin
          float_cnt_reg <= float_cnt_reg + 2'h1;
          if (!host_req) begin
            state_reg <= hbrg_pkg::ST_RESUME;
          end else if (float_cnt_reg == 2'(hbrg_pkg::FLOAT_CYCLES - 1)) begin
            state_reg <= hbrg_pkg::ST_GRANT;
          end
        end
        hbrg_pkg::ST_GRANT: begin
          if (!host_req) begin
            state_reg <= hbrg_pkg::ST_RESUME;
          end
        end
        hbrg_pkg::ST_RESUME: begin
          state_reg <= hbrg_pkg::ST_IDLE;
        end
        default: begin
          state_reg <= hbrg_pkg::ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Grant pin
  logic in_handover;
  logic grant_now;
  assign in_handover = (state_reg != hbrg_pkg::ST_IDLE);
  // Grant driven only from grant state; float before it
  // Only a bus master may drive the grant line
  assign grant_now   = (state_reg == hbrg_pkg::ST_GRANT) && host_req && own_bus_master_in;
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      host_bus_grant_oe_out <= 1'b0;
      host_bus_grant_n_out  <= 1'b1;
    end else begin
      // Released on the edge after the request goes away
      host_bus_grant_oe_out <= grant_now;
      host_bus_grant_n_out  <= ~grant_now;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // External bus drivers
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      bus_oe_out <= hbrg_pkg::BUS_OFF;
    end else begin
      // Floated throughout handover, re-driven after resume
      if (in_handover || host_req) begin
        bus_oe_out <= hbrg_pkg::BUS_OFF;
      end else if (own_bus_master_in) begin
        bus_oe_out <= hbrg_pkg::BUS_ON;
      end else begin
        bus_oe_out <= hbrg_pkg::BUS_OFF;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Host ownership flag
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      host_granted_out <= 1'b0;
    end else begin
      // Non-masters watch the grant line instead
      if (own_bus_master_in) begin
        host_granted_out <= grant_now;
      end else begin
        host_granted_out <= mon_grant;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Own peer request
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      own_bus_request_n_out <= 1'b1;
    end else begin
      // Host pending suppresses our own peer request
      own_bus_request_n_out <= ~(core_bus_want_in && !own_bus_master_in
                                 && !host_req && !in_handover);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Host wait acknowledge
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      host_wait_ack_out    <= 1'b0;
      host_wait_ack_oe_out <= 1'b0;
    end else begin
      // Open drain: drive low only, else float
      host_wait_ack_oe_out <= host_sel && host_req;
      host_wait_ack_out    <= 1'b0;
    end
  end

  // Peer requests only matter to the core's own arbiter; held for visibility
  logic unused_peer;
  assign unused_peer = peer_req;
endmodule

////////////////////////////////////////////////////////////////////
// Two-stage synchroniser for asynchronous pins
module hbrg_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             sys_rst_in,
  // Pin side and core side
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  if (WIDTH < 1) begin : g_bad_width
    $error("WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] meta_reg;
  // Resets to the idle high level, so no false request follows reset
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      meta_reg <= '1;
      sync_out <= '1;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ### dv/hbrg_chk.sv
`timescale 1ns/1ps
`default_nettype none
module hbrg_chk (
  input wire logic                   core_clk_in,
  input wire logic                   sys_rst_in,
  input wire logic                   host_bus_request_n_in,
  input wire logic                   chip_select_n_in,
  input wire logic                   own_bus_master_in,
  input wire logic                   host_bus_grant_n_out,
  input wire logic                   host_bus_grant_oe_out,
  input wire logic                   host_wait_ack_out,
  input wire logic                   host_wait_ack_oe_out,
  input wire logic                   own_bus_request_n_out,
  input wire hbrg_pkg::hbrg_bus_oe_s bus_oe_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  wire r = host_bus_request_n_in;
  wire g = host_bus_grant_oe_out;
  wire m = own_bus_master_in;
  wire off = (bus_oe_out == hbrg_pkg::BUS_OFF);
  // Nine low samples cover both sync stages and the whole handover
  sequence s_ask; (m && !r) [*8] ##1 (!r); endsequence
  sequence s_off2; off ##1 off; endsequence
  sequence s_float2; !g ##1 !g; endsequence
  property p_gnt; s_ask |-> g && !host_bus_grant_n_out; endproperty
  a_gnt: assert property (p_gnt) else $error("grant missing");
  property p_rel; g |-> off; endproperty
  a_rel: assert property (p_rel) else $error("bus driven in grant");
  property p_pri; (!r) [*4] |-> own_bus_request_n_out; endproperty
  a_pri: assert property (p_pri) else $error("peer request over host");
  // Request seen two samples back keeps a standing grant up
  property p_hold; !r ##2 g |=> g && !host_bus_grant_n_out; endproperty
  a_hold: assert property (p_hold) else $error("grant dropped early");
  property p_drop; $rose(r) && g |-> ##[1:4] !g; endproperty
  a_drop: assert property (p_drop) else $error("grant kept");
  property p_mst; $rose(g) |-> $past(m); endproperty
  a_mst: assert property (p_mst) else $error("grant by non master");
  property p_flt; $rose(g) |-> $past(off, 2); endproperty
  a_flt: assert property (p_flt) else $error("no float cycle");
  property p_gap; $fell(r) && !g |=> s_float2; endproperty
  a_gap: assert property (p_gap) else $error("grant driven without float");
  property p_lvl; host_wait_ack_oe_out |-> !host_wait_ack_out; endproperty
  a_lvl: assert property (p_lvl) else $error("wait ack driven high");
  property p_ack; (!chip_select_n_in && !r) [*4] |-> host_wait_ack_oe_out; endproperty
  a_ack: assert property (p_ack) else $error("no wait ack");
  property p_res; $fell(g) |-> s_off2; endproperty
  a_res: assert property (p_res) else $error("bus resumed early");
endmodule
bind hbrg_top hbrg_chk hbrg_chk_inst (
  .core_clk_in           (core_clk_in),
  .sys_rst_in            (sys_rst_in),
  .host_bus_request_n_in (host_bus_request_n_in),
  .chip_select_n_in      (chip_select_n_in),
  .own_bus_master_in     (own_bus_master_in),
  .host_bus_grant_n_out  (host_bus_grant_n_out),
  .host_bus_grant_oe_out (host_bus_grant_oe_out),
  .host_wait_ack_out     (host_wait_ack_out),
  .host_wait_ack_oe_out  (host_wait_ack_oe_out),
  .own_bus_request_n_out (own_bus_request_n_out),
  .bus_oe_out            (bus_oe_out)
);
`default_nettype wire

// ### dv/hbrg_host.sv
`timescale 1ns/1ps
`default_nettype none
module hbrg_host (
  // Clock
  input  wire logic clk_in,
  // Bench intent
  input  wire logic want_in,
  input  wire logic sel_in,
  // Host pins, active low
  output var  logic req_n_out = 1'b1,
  output var  logic cs_n_out  = 1'b1
);
  logic want_reg = 1'b0;
  logic sel_reg  = 1'b0;
  // Intent taken on the rising edge so bench writes never race the pins
  always @(posedge clk_in) begin
    want_reg <= want_in;
    sel_reg  <= sel_in;
  end
  // Pins move on the falling edge, clear of sampling
  always @(negedge clk_in) req_n_out <= !want_reg;
  always @(negedge clk_in) cs_n_out <= !sel_reg;
endmodule
`default_nettype wire

// ### dv/host_bus_request_grant_tb.sv
`timescale 1ns/1ps
`default_nettype none
module host_bus_request_grant_tb;
  logic clk = 0, rst = 1, want = 0, sel = 0, m = 1, cw = 1, og = 0;
  logic [5:0] pr = 6'h3F;
  wire logic rq, cs, gn, goe, ack, aoe, orq, hg;
  wire hbrg_pkg::hbrg_bus_oe_s boe;
  // Pull-up on the grant wire; og stands for another master granting
  wire logic gw = goe ? gn : !og;
  int error_cnt = 0, tests_run = 0;
  initial forever #4 clk = ~clk;
  hbrg_top hbrg_top_inst (.core_clk_in(clk), .sys_rst_in(rst), .host_bus_request_n_in(rq),
    .chip_select_n_in(cs), .host_bus_grant_n_in(gw), .host_bus_grant_n_out(gn),
    .host_bus_grant_oe_out(goe), .host_wait_ack_out(ack), .host_wait_ack_oe_out(aoe),
    .peer_bus_requests_n_in(pr), .own_bus_master_in(m), .own_bus_request_n_out(orq),
    .core_bus_want_in(cw), .bus_oe_out(boe), .host_granted_out(hg));
  hbrg_host hbrg_host_inst (.clk_in(clk), .want_in(want), .sel_in(sel), .req_n_out(rq),
    .cs_n_out(cs));
  task chk(string n, logic [3:0] s, logic [3:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask
  task tally_and_finish;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task wt(logic v);
    int i;
    for (i = 0; i < 20 && gw !== !v; i++) @(negedge clk);
    if (i == 20) begin
      chk("timeout", 1, 0);
      tally_and_finish;
    end
  endtask
  task t_grant;
    want = 1;
    sel = 1;
    wt(1);
    chk("bus", boe, 0);
    chk("granted", hg, 1);
    chk("ack", aoe, 1);
    chk("ack level", ack, 0);
    repeat (10) @(negedge clk);
    chk("held", gw, 0);
    want = 0;
    sel = 0;
    wt(0);
    chk("ungranted", hg, 0);
    chk("ack off", aoe, 0);
    chk("resume", boe, 0);
    @(negedge clk);
    chk("resume late", boe, 0);
    repeat (2) @(negedge clk);
    chk("back", boe, 4'hF);
  endtask
  task t_refuse;
    m = 0;
    want = 1;
    repeat (20) @(negedge clk);
    chk("nodrive", goe, 0);
    chk("not granted", hg, 0);
    og = 1;
    repeat (4) @(negedge clk);
    chk("monitor", hg, 1);
    og = 0;
    want = 0;
    repeat (4) @(negedge clk);
    chk("monitor off", hg, 0);
  endtask
  task t_peer;
    pr = 6'h00;
    repeat (6) @(negedge clk);
    chk("own req", orq, 0);
    want = 1;
    repeat (6) @(negedge clk);
    chk("yield", orq, 1);
    want = 0;
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst = 0;
    t_grant;
    t_refuse;
    t_peer;
    tally_and_finish;
  end
endmodule
`default_nettype wire
